//--- logic/bsd_cfg.svh
`ifndef BSD_CFG_SVH
`define BSD_CFG_SVH
`define BSD_CHAIN_LEN 186
`define BSD_PIN_CNT 62
`define BSD_IR_LEN 4
`define BSD_IR_EXTEST 4'h0
`define BSD_IR_SAMPLE 4'h1
`define BSD_IR_SCAN_N 4'h2
`define BSD_IR_INTEST 4'hC
`define BSD_IR_IDCODE 4'hE
`define BSD_IR_BYPASS 4'hF
`define BSD_IR_CAPTURE 4'h1
`define BSD_CHAIN_SEL_LEN 4
`define BSD_STRAP_WAIT 2'h2
// Arbitrary neutral identity values
`define BSD_PROC_ID 32'h1234_5671
`define BSD_CHIP_ID 32'h0BAD_0001
`endif

//--- logic/bsd_pkg.sv
package bsd_pkg;
  typedef enum logic [15:0] {
    TLR = 16'h0001, RTI = 16'h0002, SDS = 16'h0004, CDR = 16'h0008,
    SDR = 16'h0010, E1D = 16'h0020, PDR = 16'h0040, E2D = 16'h0080,
    UDR = 16'h0100, SIS = 16'h0200, CIR = 16'h0400, SIR = 16'h0800,
    E1I = 16'h1000, PIR = 16'h2000, E2I = 16'h4000, UIR = 16'h8000
  } bsd_tap_t;
  typedef struct packed {
    logic [3:0] chain_sel;
    logic capture;
    logic shift;
    logic update;
    logic tdi;
  } bsd_emu_t;
endpackage : bsd_pkg

//--- logic/bsd_top.sv
`timescale 1ns/1ps
`include "bsd_cfg.svh"
// Behaviour
// - A low scan select routes the test port to the emulation logic.
// - A high scan select routes the test port to boundary scan.
// - The selection is taken only at chip reset and never while running.
// - Boundary scan offers the sample, external test and bypass orders.
// - Emulation mode returns a private processor identity value.
// - The pin scan register is exactly 186 cells long.
// - Each two-way pin owns three cells: input, output and direction.
// - During external test the output cell value drives the pad.
// - The input cell samples the pad level at capture.
// - The direction cell chooses between driving the pad and input.
// - Cells count down in threes from 185, input cell highest.
// - Three processor chains are reachable in emulation mode.
// - In halt state a store multiple may be inserted for export.
// - Channel transmit and receive activity raise interrupts.
// - A 32-bit read-only identity register reports the product.
module bsd_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic scan_port_select,
  input wire logic factory_mode_pin,
  output logic factory_mode_err,
  output logic bscan_mode,
  input wire logic [`BSD_PIN_CNT-1:0] pad_in,
  output logic [`BSD_PIN_CNT-1:0] pad_out,
  output logic [`BSD_PIN_CNT-1:0] pad_oe,
  input wire logic [`BSD_PIN_CNT-1:0] core_out,
  input wire logic [`BSD_PIN_CNT-1:0] core_oe,
  output logic [`BSD_PIN_CNT-1:0] core_in,
  input wire logic [2:0] emu_tdo_in,
  input wire logic halt_debug,
  output bsd_pkg::bsd_emu_t emu,
  output logic store_multiple_insert,
  input wire logic debug_channel_tx_flag,
  input wire logic debug_channel_rx_flag,
  output logic comm_tx_irq,
  output logic comm_rx_irq,
  output logic [31:0] chip_id
);
  import bsd_pkg::*;

  localparam int N = `BSD_CHAIN_LEN;
  localparam int P = `BSD_PIN_CNT;

  logic [2:0] tck_s;
  logic tms_s1, tms_s2, tdi_s1, tdi_s2;
  logic [P-1:0] pad_s1, pad_s2;
  logic sel_s1, sel_s2, fm_s1, fm_s2;
  logic [1:0] strap_cnt_reg;
  logic sel_done_reg;
  bsd_tap_t state_reg, state_next;
  logic [3:0] ir_reg, ir_sh_reg;
  logic [N-1:0] bsr_sh_reg, bsr_upd_reg;
  logic [31:0] id_sh_reg;
  logic [3:0] csel_sh_reg;
  logic byp_reg;
  logic extest_reg;

  wire tck_rise = tck_s[1] & ~tck_s[2];
  wire tck_fall = ~tck_s[1] & tck_s[2];
  wire run = sel_done_reg;
  wire in_cdr = state_reg == CDR;
  wire in_sdr = state_reg == SDR;
  wire in_udr = state_reg == UDR;
  wire in_sir = state_reg == SIR;
  // Modes decoded per selected port
  wire is_ext = bscan_mode && ir_reg == `BSD_IR_EXTEST;
  wire is_smp = bscan_mode && ir_reg == `BSD_IR_SAMPLE;
  wire bsr_sel = is_ext || is_smp;
  wire id_sel = !bscan_mode && ir_reg == `BSD_IR_IDCODE;
  wire csel_sel = !bscan_mode && ir_reg == `BSD_IR_SCAN_N;
  wire chain_sel = !bscan_mode && ir_reg == `BSD_IR_INTEST;
  wire chain_tdo = emu.chain_sel < 4'h3 ? emu_tdo_in[emu.chain_sel[1:0]]
                                        : 1'b0;
  wire dr_lsb = bsr_sel ? bsr_sh_reg[0] : id_sel ? id_sh_reg[0] :
                csel_sel ? csel_sh_reg[0] : chain_sel ? chain_tdo : byp_reg;
  wire tdo_src = in_sir ? ir_sh_reg[0] : dr_lsb;

  logic [P-1:0] cell_out, cell_ctl, pad_cap;
  genvar g;
  generate
    for (g = 0; g < P; g++) begin : gen_pin
      assign cell_out[g] = bsr_upd_reg[N-2-3*g];
      assign cell_ctl[g] = bsr_upd_reg[N-3-3*g];
      assign pad_cap[g] = pad_s2[g];
    end
  endgenerate

  function automatic logic [N-1:0] capture_pins(
    input logic [P-1:0] pi, input logic [N-1:0] upd);
    logic [N-1:0] v;
    v = upd;
    for (int k = 0; k < P; k++) begin
      v[N-1-3*k] = pi[k];
    end
    return v;
  endfunction : capture_pins

  always_comb begin
    unique case (state_reg)
      TLR: state_next = tms_s2 ? TLR : RTI;
      RTI: state_next = tms_s2 ? SDS : RTI;
      SDS: state_next = tms_s2 ? SIS : CDR;
      CDR: state_next = tms_s2 ? E1D : SDR;
      SDR: state_next = tms_s2 ? E1D : SDR;
      E1D: state_next = tms_s2 ? UDR : PDR;
      PDR: state_next = tms_s2 ? E2D : PDR;
      E2D: state_next = tms_s2 ? UDR : SDR;
      UDR: state_next = tms_s2 ? SDS : RTI;
      SIS: state_next = tms_s2 ? TLR : CIR;
      CIR: state_next = tms_s2 ? E1I : SIR;
      SIR: state_next = tms_s2 ? E1I : SIR;
      E1I: state_next = tms_s2 ? UIR : PIR;
      PIR: state_next = tms_s2 ? E2I : PIR;
      E2I: state_next = tms_s2 ? UIR : SIR;
      UIR: state_next = tms_s2 ? SDS : RTI;
      default: state_next = TLR;
    endcase
  end

  // Pin level inputs cross two flops first
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tck_s <= 3'h0;
      {tms_s1, tms_s2, tdi_s1, tdi_s2} <= 4'h0;
      {sel_s1, sel_s2, fm_s1, fm_s2} <= 4'h0;
      pad_s1 <= '0;
      pad_s2 <= '0;
    end else begin
      tck_s <= {tck_s[1:0], tck};
      {tms_s1, tms_s2} <= {tms, tms_s1};
      {tdi_s1, tdi_s2} <= {tdi, tdi_s1};
      {sel_s1, sel_s2} <= {scan_port_select, sel_s1};
      {fm_s1, fm_s2} <= {factory_mode_pin, fm_s1};
      pad_s1 <= pad_in;
      pad_s2 <= pad_s1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strap_cnt_reg <= 2'h0;
      sel_done_reg <= 1'b0;
      bscan_mode <= 1'b0;
    end else if (!sel_done_reg) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == `BSD_STRAP_WAIT) begin
        bscan_mode <= sel_s2;
        sel_done_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= TLR;
    end else if (run && tck_rise) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ir_reg <= `BSD_IR_BYPASS;
      ir_sh_reg <= `BSD_IR_CAPTURE;
    end else if (run && tck_rise) begin
      if (state_reg == TLR) begin
        ir_reg <= bscan_mode ? `BSD_IR_BYPASS : `BSD_IR_IDCODE;
      end else if (state_reg == CIR) begin
        ir_sh_reg <= `BSD_IR_CAPTURE;
      end else if (in_sir) begin
        ir_sh_reg <= {tdi_s2, ir_sh_reg[3:1]};
      end else if (state_reg == UIR) begin
        ir_reg <= ir_sh_reg;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bsr_sh_reg <= '0;
      bsr_upd_reg <= '0;
      byp_reg <= 1'b0;
      extest_reg <= 1'b0;
    end else if (run && tck_rise) begin
      // Order acts from update-IR on, dropped when entering reset
      extest_reg <= bscan_mode && state_reg != TLR && state_next != TLR &&
                    (state_reg == UIR ? ir_sh_reg : ir_reg) == `BSD_IR_EXTEST;
      if (in_cdr) begin
        byp_reg <= 1'b0;
        if (bsr_sel) bsr_sh_reg <= capture_pins(pad_cap, bsr_upd_reg);
      end else if (in_sdr) begin
        byp_reg <= tdi_s2;
        if (bsr_sel) bsr_sh_reg <= {tdi_s2, bsr_sh_reg[N-1:1]};
      end else if (in_udr && bsr_sel) begin
        bsr_upd_reg <= bsr_sh_reg;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      id_sh_reg <= '0;
      csel_sh_reg <= 4'h0;
      emu <= '0;
      store_multiple_insert <= 1'b0;
    end else begin
      emu.capture <= run && tck_rise && in_cdr && chain_sel;
      emu.shift <= run && tck_rise && in_sdr && chain_sel;
      emu.update <= run && tck_rise && in_udr && chain_sel;
      emu.tdi <= tdi_s2;
      store_multiple_insert <= run && tck_rise && in_udr && chain_sel &&
                               halt_debug && emu.chain_sel == 4'h1;
      if (run && tck_rise) begin
        if (in_cdr) begin
          id_sh_reg <= `BSD_PROC_ID;
          csel_sh_reg <= emu.chain_sel;
        end else if (in_sdr) begin
          id_sh_reg <= {tdi_s2, id_sh_reg[31:1]};
          csel_sh_reg <= {tdi_s2, csel_sh_reg[3:1]};
        end else if (in_udr && csel_sel) begin
          emu.chain_sel <= csel_sh_reg;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (run && tck_fall) begin
      tdo <= tdo_src;
      tdo_oe <= in_sdr || in_sir;
    end
  end

  // cells drive pads in external test
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pad_out <= '0;
      pad_oe <= '0;
      core_in <= '0;
    end else begin
      pad_out <= extest_reg ? cell_out : core_out;
      pad_oe <= extest_reg ? cell_ctl : core_oe;
      core_in <= pad_s2;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      comm_tx_irq <= 1'b0;
      comm_rx_irq <= 1'b0;
      chip_id <= 32'h0000_0000;
      factory_mode_err <= 1'b0;
    end else begin
      comm_tx_irq <= debug_channel_tx_flag;
      comm_rx_irq <= debug_channel_rx_flag;
      chip_id <= `BSD_CHIP_ID;
      factory_mode_err <= fm_s2;
    end
  end
endmodule : bsd_top

//--- verif/bsd_tester.sv
`timescale 1ns/1ps
module bsd_tester (
  input wire logic sys_clk,
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi
);
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
  end
  // eight clock cycle, tdo read before fall
  task automatic cyc(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    tck <= 1'h0;
    repeat (4) @(posedge sys_clk);
    tck <= 1'h1;
    repeat (4) @(posedge sys_clk);
    q = tdo;
  endtask : cyc
endmodule : bsd_tester

//--- verif/bsd_top_props.sv
`timescale 1ns/1ps
`include "bsd_cfg.svh"
module bsd_top_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic bscan_mode,
  input wire logic [`BSD_PIN_CNT-1:0] pad_out,
  input wire logic [`BSD_PIN_CNT-1:0] pad_oe,
  input wire logic [`BSD_PIN_CNT-1:0] core_out,
  input wire logic [`BSD_PIN_CNT-1:0] core_oe,
  input wire bsd_pkg::bsd_emu_t emu,
  input wire logic store_multiple_insert,
  input wire logic debug_channel_tx_flag,
  input wire logic debug_channel_rx_flag,
  input wire logic comm_tx_irq,
  input wire logic comm_rx_irq,
  input wire logic [31:0] chip_id
);
  import bsd_pkg::*;
  logic [2:0] up_cnt;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Strap latch needs a few edges before it is final
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) up_cnt <= 3'h0;
    else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
  end
  // Tester holds tck high only four edges, so no fall update of tdo shows here
  sequence tck_high_run;
    tck [*3];
  endsequence
  mode_hold_a: assert property (
    up_cnt == 3'h7 |-> $stable(bscan_mode))
    else $error("scan mode changed while running");
  tdo_hold_a: assert property (
    tck_high_run |-> $stable({tdo, tdo_oe}))
    else $error("tdo moved without a test clock fall");
  emu_quiet_a: assert property (
    bscan_mode |-> !(emu.capture || emu.shift || emu.update))
    else $error("emulation pulse in scan mode");
  store_mult_a: assert property (
    store_multiple_insert |-> emu.update && !bscan_mode)
    else $error("store insert without update");
  pad_emu_a: assert property (
    up_cnt == 3'h7 && !bscan_mode |=>
      pad_out == $past(core_out) && pad_oe == $past(core_oe))
    else $error("pads not following core");
  irq_tx_a: assert property (
    up_cnt != 3'h0 |-> comm_tx_irq == $past(debug_channel_tx_flag))
    else $error("tx irq mismatch");
  irq_rx_a: assert property (
    up_cnt != 3'h0 |-> comm_rx_irq == $past(debug_channel_rx_flag))
    else $error("rx irq mismatch");
  chip_id_a: assert property (
    up_cnt != 3'h0 |-> chip_id == `BSD_CHIP_ID)
    else $error("chip id wrong");
endmodule : bsd_top_props
bind bsd_top bsd_top_props i_props (.*);

//--- verif/testbench.sv
`timescale 1ns/1ps
`include "bsd_cfg.svh"
module testbench;
  import bsd_pkg::*;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic scan_port_select = 1'h1;
  logic debug_channel_tx_flag = 1'h0;
  logic debug_channel_rx_flag = 1'h0;
  logic halt_debug = 1'h0;
  logic [2:0] emu_tdo_in = 3'h0;
  logic [61:0] pad_in = '0;
  logic [61:0] core_out = '0;
  logic [61:0] core_oe = '0;
  logic [61:0] pad_out, pad_oe;
  logic [61:0] core_in;
  logic tck, tms, tdi, tdo, bscan_mode, comm_tx_irq, comm_rx_irq;
  logic fm_err, smi;
  int shift_n = 0;
  int smi_n = 0;
  logic [31:0] chip_id;
  bsd_emu_t emu;
  logic [185:0] w, q, m;
  int fail_count = 0;
  int checks_done = 0;
  int cyc_n = 0;
  bsd_top i_dut (.sys_clk, .rst, .tck, .tms, .tdi, .tdo, .tdo_oe(),
    .scan_port_select, .factory_mode_pin(1'h0), .factory_mode_err(fm_err),
    .bscan_mode, .pad_in, .pad_out, .pad_oe, .core_out, .core_oe,
    .core_in, .emu_tdo_in, .halt_debug, .emu, .store_multiple_insert(smi),
    .debug_channel_tx_flag, .debug_channel_rx_flag, .comm_tx_irq,
    .comm_rx_irq, .chip_id);
  bsd_tester i_tst (.sys_clk, .tdo, .tck, .tms, .tdi);
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc_n++;
    if (emu.shift) shift_n++;
    if (smi) smi_n++;
    if (cyc_n == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d fails %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [185:0] got, input logic [185:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [185:0] rnd();
    logic [191:0] t;
    t = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
    return t[185:0];
  endfunction : rnd
  function automatic logic [185:0] in_cells(input logic [61:0] p);
    in_cells = '0;
    for (int k = 0; k < 62; k++) in_cells[185-3*k] = p[k];
  endfunction : in_cells
  function automatic logic [61:0] pick(input logic [185:0] v, input int o);
    for (int k = 0; k < 62; k++) pick[k] = v[185-o-3*k];
  endfunction : pick
  task automatic scan(input logic ir, input logic [185:0] v, input int n,
    output logic [185:0] r);
    logic b;
    r = '0;
    i_tst.cyc(1'h1, 1'h0, b);
    if (ir) i_tst.cyc(1'h1, 1'h0, b);
    i_tst.cyc(1'h0, 1'h0, b);
    i_tst.cyc(1'h0, 1'h0, b);
    for (int i = 0; i < n; i++) i_tst.cyc(i == n - 1, v[i], r[i]);
    i_tst.cyc(1'h1, 1'h0, b);
    i_tst.cyc(1'h0, 1'h0, b);
  endtask : scan
  task automatic do_rst(input logic s);
    logic b;
    scan_port_select <= s;
    rst <= 1'h1;
    repeat (8) @(posedge sys_clk);
    rst <= 1'h0;
    repeat (10) @(posedge sys_clk);
    for (int i = 0; i < 6; i++) i_tst.cyc(i < 5, 1'h0, b);
  endtask : do_rst
  initial begin
    void'($urandom(32'h96d8_5dff));
    do_rst(1'h1);
    chk(bscan_mode, 1'h1);
    scan(1'h1, 186'h1, 4, q);
    chk(q[3:0], 4'h1);
    w = rnd();
    pad_in <= w[185:124];
    w = rnd();
    scan(1'h0, w, 186, q);
    m = in_cells('1);
    chk(q & m, in_cells(pad_in));
    chk(core_in, pad_in);
    chk(fm_err, 1'h0);
    scan(1'h1, 186'h0, 4, q);
    repeat (4) @(posedge sys_clk);
    chk(pad_out, pick(w, 1));
    chk(pad_oe, pick(w, 2));
    scan(1'h0, rnd(), 186, q);
    chk(q & ~m, w & ~m);
    $display("boundary test done");
    scan(1'h1, 186'hF, 4, q);
    scan(1'h0, w, 8, q);
    chk(q[7:0], {w[6:0], 1'h0});
    $display("bypass test done");
    do_rst(1'h0);
    chk(bscan_mode, 1'h0);
    scan_port_select <= 1'h1;
    repeat (20) @(posedge sys_clk);
    chk(bscan_mode, 1'h0);
    scan(1'h0, 186'h0, 32, q);
    chk(q[31:0], `BSD_PROC_ID);
    chk(chip_id, `BSD_CHIP_ID);
    w = rnd();
    {debug_channel_tx_flag, debug_channel_rx_flag} <= w[1:0];
    {halt_debug, emu_tdo_in} <= w[67:64];
    core_out <= w[63:2];
    core_oe <= w[129:68];
    repeat (3) @(posedge sys_clk);
    chk({comm_tx_irq, comm_rx_irq}, w[1:0]);
    chk({pad_out, pad_oe}, {w[63:2], w[129:68]});
    halt_debug <= 1'h1;
    scan(1'h1, 186'h2, 4, q);
    scan(1'h0, 186'h1, 4, q);
    chk(emu.chain_sel, 4'h1);
    scan(1'h1, 186'hC, 4, q);
    scan(1'h0, 186'h0, 8, q);
    repeat (2) @(posedge sys_clk);
    chk(q[7:0], {8{w[65]}});
    chk(shift_n, 8);
    chk(smi_n, 1);
    $display("emulation test done");
    tally_and_finish();
  end
endmodule : testbench
